/* File: anps_link_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// far side: negotiation logic feeding received pages and levels
// ----------------------------------------------------------------
module anps_link_model
(
    input  wire logic        clk,
    output var  logic        page_rx_stb,
    output var  logic [15:0] page_word,
    output var  logic        partner_an_detected,
    output var  logic        parallel_fault
);

    // idle values at time zero; the word is junk outside a strobe
    initial
    begin
        page_rx_stb         = 1'b0;
        page_word           = 16'hA5A5;
        partner_an_detected = 1'b0;
        parallel_fault      = 1'b0;
    end

    // one received code word, ack bit comes from the burst itself
    task automatic send_page(input logic [15:0] w);
        @(posedge clk);
        page_rx_stb <= 1'b1;
        page_word   <= w;
        @(posedge clk);
        page_rx_stb <= 1'b0;
        page_word   <= ~w; // word no longer valid, not held
    endtask : send_page

    // partner autoneg detection level
    task automatic set_an(input logic v);
        @(posedge clk);
        partner_an_detected <= v;
    endtask : set_an

    // parallel detection fault level
    task automatic set_fault(input logic v);
        @(posedge clk);
        parallel_fault <= v;
    endtask : set_fault

endmodule : anps_link_model

`default_nettype wire

/* File: anps_partner_status.sv */
`timescale 1ns/1ps
`default_nettype none

module anps_partner_status
(
    input  wire logic        clk,
    input  wire logic        nrst,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // from the negotiation state machine
    input  wire logic        page_rx_stb,
    input  wire logic [15:0] page_word,
    input  wire logic        partner_an_detected,
    input  wire logic        parallel_fault,
    // interrupt
    output var  logic        irq
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        bus_acc;
    logic        bus_rd;
    logic        bus_wr;
    logic        rd_exp_acc;
    logic        wr_stat;
    logic        wr_mask;
    logic [31:0] nxt_rdata;

    // one access per request, ack gives the bubble between two
    assign bus_acc    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_rd     = bus_acc && !wb_we_i;
    assign bus_wr     = bus_acc && wb_we_i && wb_sel_i[0];
    assign rd_exp_acc = bus_rd && (wb_adr_i == anps_pkg::ANPS_ADR_EXPANSION);
    assign wr_stat    = bus_wr && (wb_adr_i == anps_pkg::ANPS_ADR_INT_STAT);
    assign wr_mask    = bus_wr && (wb_adr_i == anps_pkg::ANPS_ADR_INT_MASK);

    // ------------------------------------------------------------
    // partner ability register
    // ------------------------------------------------------------
    logic [15:0] partner_ability_ff;
    logic [15:0] nxt_partner_ability;

    // map a received code word onto the ability fields
    always_comb
    begin
        nxt_partner_ability = partner_ability_ff;
        if (page_rx_stb)
        begin
            nxt_partner_ability[anps_pkg::ANPS_AB_MORE_PAGES] =
                page_word[anps_pkg::ANPS_AB_MORE_PAGES];
            nxt_partner_ability[anps_pkg::ANPS_AB_ACK] =
                page_word[anps_pkg::ANPS_AB_ACK];
            nxt_partner_ability[anps_pkg::ANPS_AB_RFAULT] =
                page_word[anps_pkg::ANPS_AB_RFAULT];
            nxt_partner_ability[anps_pkg::ANPS_AB_RSVD_HI:anps_pkg::ANPS_AB_RSVD_LO] =
                anps_pkg::ANPS_RSVD_AB_VAL;
            nxt_partner_ability[anps_pkg::ANPS_AB_PAUSE] =
                page_word[anps_pkg::ANPS_AB_PAUSE];
            nxt_partner_ability[anps_pkg::ANPS_AB_FOUR_PAIR] =
                page_word[anps_pkg::ANPS_AB_FOUR_PAIR];
            nxt_partner_ability[anps_pkg::ANPS_AB_FAST_FDX] =
                page_word[anps_pkg::ANPS_AB_FAST_FDX];
            nxt_partner_ability[anps_pkg::ANPS_AB_FAST_HDX] =
                page_word[anps_pkg::ANPS_AB_FAST_HDX];
            nxt_partner_ability[anps_pkg::ANPS_AB_TEN_FDX] =
                page_word[anps_pkg::ANPS_AB_TEN_FDX];
            nxt_partner_ability[anps_pkg::ANPS_AB_TEN_HDX] =
                page_word[anps_pkg::ANPS_AB_TEN_HDX];
            nxt_partner_ability[anps_pkg::ANPS_AB_SEL_HI:anps_pkg::ANPS_AB_SEL_LO] =
                page_word[anps_pkg::ANPS_AB_SEL_HI:anps_pkg::ANPS_AB_SEL_LO];
        end
    end

    // only the state machine updates it, bus writes never reach it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            partner_ability_ff <= anps_pkg::ANPS_ABILITY_RST;
        end
        else
        begin
            partner_ability_ff <= nxt_partner_ability;
        end
    end

    // ------------------------------------------------------------
    // expansion register
    // ------------------------------------------------------------
    logic        pdf_ff;
    logic        page_rx_ff;
    logic        partner_autoneg_capable_ff;
    logic [15:0] expansion;

    // fault latches high, read clears it only once the fault is gone
    anps_sticky u_pdf
    (
        .clk     (clk),
        .nrst    (nrst),
        .set     (parallel_fault),
        .clr     (rd_exp_acc),
        .flag_ff (pdf_ff)
    );

    // new page flag, a page arriving with the read is kept
    anps_sticky u_page
    (
        .clk     (clk),
        .nrst    (nrst),
        .set     (page_rx_stb),
        .clr     (rd_exp_acc),
        .flag_ff (page_rx_ff)
    );

    // partner autonegotiation capability tracks the detector
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            partner_autoneg_capable_ff <= 1'b0;
        end
        else
        begin
            partner_autoneg_capable_ff <= partner_an_detected;
        end
    end

    // assemble the expansion view
    always_comb
    begin
        expansion = 16'h0000;
        expansion[15:5] = anps_pkg::ANPS_RSVD_EX_VAL;
        expansion[anps_pkg::ANPS_EX_PDF] = pdf_ff;
        expansion[anps_pkg::ANPS_EX_LP_NP] =
            partner_ability_ff[anps_pkg::ANPS_AB_MORE_PAGES];
        expansion[anps_pkg::ANPS_EX_LOCAL_NP] =
            anps_pkg::ANPS_LOCAL_NP_VAL;
        expansion[anps_pkg::ANPS_EX_PAGE_RX] = page_rx_ff;
        expansion[anps_pkg::ANPS_EX_LP_AN] = partner_autoneg_capable_ff;
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [2:0] int_stat_ff;
    logic [2:0] int_mask_ff;
    logic [2:0] int_evt;
    logic       fault_prev_ff;
    logic       an_prev_ff;

    // remember inputs to catch rising edges
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_prev_ff <= 1'b0;
            an_prev_ff    <= 1'b0;
        end
        else
        begin
            fault_prev_ff <= parallel_fault;
            an_prev_ff    <= partner_an_detected;
        end
    end

    // events: new page, fault start, partner capable found
    assign int_evt[anps_pkg::ANPS_INT_PAGE] = page_rx_stb;
    assign int_evt[anps_pkg::ANPS_INT_PDF]  = parallel_fault && !fault_prev_ff;
    assign int_evt[anps_pkg::ANPS_INT_AN]   = partner_an_detected && !an_prev_ff;

    // sticky status bits, write one to clear
    genvar gi;
    generate
        for (gi = 0; gi < anps_pkg::ANPS_INT_W; gi++)
        begin : g_int
            anps_sticky u_st
            (
                .clk     (clk),
                .nrst    (nrst),
                .set     (int_evt[gi]),
                .clr     (wr_stat && wb_dat_i[gi]),
                .flag_ff (int_stat_ff[gi])
            );
        end
    endgenerate

    // mask register, software steers the interrupt line
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            int_mask_ff <= anps_pkg::ANPS_INT_RST;
        end
        else if (wr_mask)
        begin
            int_mask_ff <= wb_dat_i[2:0];
        end
    end

    // level interrupt while any unmasked bit is set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(int_stat_ff & int_mask_ff);
        end
    end

    // ------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------
    // unmapped addresses read zero, all writes except int regs ignored
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (wb_adr_i)
            anps_pkg::ANPS_ADR_ABILITY:   nxt_rdata[15:0] = partner_ability_ff;
            anps_pkg::ANPS_ADR_EXPANSION: nxt_rdata[15:0] = expansion;
            anps_pkg::ANPS_ADR_INT_STAT:  nxt_rdata[2:0]  = int_stat_ff;
            anps_pkg::ANPS_ADR_INT_MASK:  nxt_rdata[2:0]  = int_mask_ff;
            default:                      nxt_rdata       = 32'h0000_0000;
        endcase
    end

    // ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_acc;
        end
    end

    // read data sampled with the access, zero otherwise
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_rd)
        begin
            wb_dat_o <= nxt_rdata;
        end
        else
        begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_page_in;
        page_rx_stb;
    endsequence

    sequence s_exp_read;
        rd_exp_acc && !page_rx_stb;
    endsequence

    property p_capture;
        s_page_in |=> partner_ability_ff ==
            {$past(page_word[15:13]), 2'b00, $past(page_word[10:0])};
    endproperty
    a_capture: assert property (p_capture)
        else $error("ability not captured from page");

    property p_np_mirror;
        s_page_in |=> expansion[anps_pkg::ANPS_EX_LP_NP] == $past(page_word[15]);
    endproperty
    a_np_mirror: assert property (p_np_mirror)
        else $error("partner next page bit wrong");

    property p_rsvd_read;
        wb_ack_o && $past(bus_rd) |-> wb_dat_o[31:16] == 16'h0000 &&
            ($past(wb_adr_i) != anps_pkg::ANPS_ADR_EXPANSION || wb_dat_o[15:5] == 11'h000) &&
            ($past(wb_adr_i) != anps_pkg::ANPS_ADR_ABILITY || wb_dat_o[12:11] == 2'b00);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved bits read non-zero");

    property p_local_np;
        wb_ack_o && $past(rd_exp_acc) |-> !wb_dat_o[anps_pkg::ANPS_EX_LOCAL_NP];
    endproperty
    a_local_np: assert property (p_local_np)
        else $error("local next page bit read as one");

    property p_page_flag;
        s_page_in |=> page_rx_ff ##1 (page_rx_ff || $past(rd_exp_acc));
    endproperty
    a_page_flag: assert property (p_page_flag)
        else $error("page received flag not held");

    property p_page_clear;
        s_exp_read |=> !page_rx_ff;
    endproperty
    a_page_clear: assert property (p_page_clear)
        else $error("page flag not cleared by read");

    property p_pdf_latch;
        parallel_fault ##1 (!parallel_fault)[*2] |-> pdf_ff || $past(rd_exp_acc, 1);
    endproperty
    a_pdf_latch: assert property (p_pdf_latch)
        else $error("fault bit did not latch");

    property p_pdf_clear;
        rd_exp_acc && !parallel_fault |=> !pdf_ff;
    endproperty
    a_pdf_clear: assert property (p_pdf_clear)
        else $error("fault bit not cleared after read");

    property p_an_able;
        ##1 partner_autoneg_capable_ff == $past(partner_an_detected);
    endproperty
    a_an_able: assert property (p_an_able)
        else $error("autoneg capable bit lags wrongly");

    property p_ack_pulse;
        bus_acc |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a single cycle pulse");

    property p_irq;
        ##1 irq == $past(|(int_stat_ff & int_mask_ff));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow masked status");

endmodule : anps_partner_status

`default_nettype wire

/* File: anps_partner_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// testbench
// ----------------------------------------------------------------
module anps_partner_status_tb;

    logic        clk;
    logic        nrst;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w;
    logic [31:0] wb_dat_r;
    logic        wb_ack;
    logic        page_rx_stb;
    logic [15:0] page_word;
    logic        an_det;
    logic        pd_fault;
    logic        irq;
    logic [15:0] w;
    logic [31:0] rdv;
    logic [31:0] exp_ab;
    logic [31:0] exp_ex;
    int          n_fail;
    int          compares;

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    anps_partner_status anps_partner_status_i
    (
        .clk                 (clk),
        .nrst                (nrst),
        .wb_cyc_i            (wb_cyc),
        .wb_stb_i            (wb_stb),
        .wb_we_i             (wb_we),
        .wb_adr_i            (wb_adr),
        .wb_sel_i            (wb_sel),
        .wb_dat_i            (wb_dat_w),
        .wb_dat_o            (wb_dat_r),
        .wb_ack_o            (wb_ack),
        .page_rx_stb         (page_rx_stb),
        .page_word           (page_word),
        .partner_an_detected (an_det),
        .parallel_fault      (pd_fault),
        .irq                 (irq)
    );

    anps_link_model anps_link_model_i
    (
        .clk                 (clk),
        .page_rx_stb         (page_rx_stb),
        .page_word           (page_word),
        .partner_an_detected (an_det),
        .parallel_fault      (pd_fault)
    );

    // ----------------------------------------------------------------
    // helper tasks
    // ----------------------------------------------------------------

    // verdict and end of run
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle, held until ack is seen at a rising edge
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= 4'h1;
        wb_dat_w <= wd;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        // ack and read data sampled at the same rising edge, released right after it
        rd = wb_dat_r;
        if (wb_ack !== 1'b1)
        begin
            n_fail++;
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : xfer

    // read and compare
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        xfer(1'b0, adr, 32'h0000_0000, rd);
        check(rd, exp);
    endtask : rd_chk

    // compare only the bits under a mask
    task automatic fld_chk(input logic [31:0] seen, input logic [31:0] exp,
                           input logic [31:0] m);
        check(seen & m, exp & m);
    endtask : fld_chk

    // write
    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] rd;
        xfer(1'b1, adr, wd, rd);
    endtask : wr

    // irq is registered, let it settle then compare
    task automatic irq_chk(input logic e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check({31'h0000_0000, irq}, {31'h0000_0000, e});
    endtask : irq_chk

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        n_fail   = 0;
        compares = 0;
        nrst     = 1'b0;
        wb_cyc   = 1'b0;
        wb_stb   = 1'b0;
        wb_we    = 1'b0;
        wb_adr   = 8'h00;
        wb_sel   = 4'h0;
        wb_dat_w = 32'h0000_0000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        // values after reset
        rd_chk(anps_pkg::ANPS_ADR_ABILITY, 32'h0000_0000);
        rd_chk(anps_pkg::ANPS_ADR_EXPANSION, 32'h0000_0000);
        rd_chk(anps_pkg::ANPS_ADR_INT_STAT, 32'h0000_0000);
        rd_chk(anps_pkg::ANPS_ADR_INT_MASK, 32'h0000_0000);
        // walk a one through every page bit, reserved pair always sent high
        for (int i = 0; i < 17; i++)
        begin
            w = (i == 16) ? 16'hFFFF : (16'h1800 | (16'h0001 << i));
            anps_link_model_i.send_page(w);
            exp_ab = {16'h0000, w & 16'hE7FF};
            exp_ex = {28'h0000000, w[15], 3'b010};
            xfer(1'b0, anps_pkg::ANPS_ADR_ABILITY, 32'h0000_0000, rdv);
            fld_chk(rdv, exp_ab, 32'h0000_8000);
            fld_chk(rdv, exp_ab, 32'h0000_4000);
            fld_chk(rdv, exp_ab, 32'h0000_2000);
            fld_chk(rdv, exp_ab, 32'h0000_1800);
            fld_chk(rdv, exp_ab, 32'h0000_0400);
            fld_chk(rdv, exp_ab, 32'h0000_0200);
            fld_chk(rdv, exp_ab, 32'h0000_0100);
            fld_chk(rdv, exp_ab, 32'h0000_0080);
            fld_chk(rdv, exp_ab, 32'h0000_0040);
            fld_chk(rdv, exp_ab, 32'h0000_0020);
            fld_chk(rdv, exp_ab, 32'h0000_001F);
            fld_chk(rdv, exp_ab, 32'hFFFF_FFFF);
            rd_chk(anps_pkg::ANPS_ADR_EXPANSION, exp_ex);
            rd_chk(anps_pkg::ANPS_ADR_EXPANSION, {28'h0, w[15], 3'b000});
        end
        // writes to read-only places have no effect
        wr(anps_pkg::ANPS_ADR_ABILITY, 32'h0000_0000);
        rd_chk(anps_pkg::ANPS_ADR_ABILITY, 32'h0000_E7FF);
        wr(anps_pkg::ANPS_ADR_EXPANSION, 32'h0000_FFFF);
        rd_chk(anps_pkg::ANPS_ADR_EXPANSION, 32'h0000_0008);
        // page events stay masked, then unmask and clear
        irq_chk(1'b0);
        rd_chk(anps_pkg::ANPS_ADR_INT_STAT, 32'h0000_0001);
        wr(anps_pkg::ANPS_ADR_INT_MASK, 32'h0000_0007);
        rd_chk(anps_pkg::ANPS_ADR_INT_MASK, 32'h0000_0007);
        irq_chk(1'b1);
        wr(anps_pkg::ANPS_ADR_INT_STAT, 32'h0000_0001);
        rd_chk(anps_pkg::ANPS_ADR_INT_STAT, 32'h0000_0000);
        irq_chk(1'b0);
        // partner autoneg and a parallel fault that comes and goes
        anps_link_model_i.set_an(1'b1);
        anps_link_model_i.set_fault(1'b1);
        irq_chk(1'b1);
        rd_chk(anps_pkg::ANPS_ADR_INT_STAT, 32'h0000_0006);
        rd_chk(anps_pkg::ANPS_ADR_EXPANSION, 32'h0000_0019);
        rd_chk(anps_pkg::ANPS_ADR_EXPANSION, 32'h0000_0019);
        anps_link_model_i.set_fault(1'b0);
        rd_chk(anps_pkg::ANPS_ADR_EXPANSION, 32'h0000_0019);
        rd_chk(anps_pkg::ANPS_ADR_EXPANSION, 32'h0000_0009);
        // clear one status bit only, then mask the rest
        wr(anps_pkg::ANPS_ADR_INT_STAT, 32'h0000_0002);
        rd_chk(anps_pkg::ANPS_ADR_INT_STAT, 32'h0000_0004);
        irq_chk(1'b1);
        wr(anps_pkg::ANPS_ADR_INT_MASK, 32'h0000_0000);
        irq_chk(1'b0);
        // unmapped address reads zero
        rd_chk(8'h40, 32'h0000_0000);
        final_report();
    end

endmodule : anps_partner_status_tb

`default_nettype wire

/* File: anps_pkg.sv */
// ----------------------------------------------------------------
// partner status register constants
// ----------------------------------------------------------------
package anps_pkg;

    // register indices and their byte addresses (index times four)
    localparam logic [7:0]  ANPS_IDX_ABILITY   = 8'h05;
    localparam logic [7:0]  ANPS_IDX_EXPANSION = 8'h06;
    localparam logic [7:0]  ANPS_IDX_INT_STAT  = 8'h08;
    localparam logic [7:0]  ANPS_IDX_INT_MASK  = 8'h09;
    localparam logic [7:0]  ANPS_ADR_ABILITY   = {ANPS_IDX_ABILITY[5:0], 2'b00};
    localparam logic [7:0]  ANPS_ADR_EXPANSION = {ANPS_IDX_EXPANSION[5:0], 2'b00};
    localparam logic [7:0]  ANPS_ADR_INT_STAT  = {ANPS_IDX_INT_STAT[5:0], 2'b00};
    localparam logic [7:0]  ANPS_ADR_INT_MASK  = {ANPS_IDX_INT_MASK[5:0], 2'b00};

    // partner ability field positions
    localparam int          ANPS_AB_MORE_PAGES = 15;
    localparam int          ANPS_AB_ACK        = 14;
    localparam int          ANPS_AB_RFAULT     = 13;
    localparam int          ANPS_AB_RSVD_HI    = 12;
    localparam int          ANPS_AB_RSVD_LO    = 11;
    localparam int          ANPS_AB_PAUSE      = 10;
    localparam int          ANPS_AB_FOUR_PAIR  = 9;
    localparam int          ANPS_AB_FAST_FDX   = 8;
    localparam int          ANPS_AB_FAST_HDX   = 7;
    localparam int          ANPS_AB_TEN_FDX    = 6;
    localparam int          ANPS_AB_TEN_HDX    = 5;
    localparam int          ANPS_AB_SEL_HI     = 4;
    localparam int          ANPS_AB_SEL_LO     = 0;

    // expansion field positions
    localparam int          ANPS_EX_PDF        = 4;
    localparam int          ANPS_EX_LP_NP      = 3;
    localparam int          ANPS_EX_LOCAL_NP   = 2;
    localparam int          ANPS_EX_PAGE_RX    = 1;
    localparam int          ANPS_EX_LP_AN      = 0;

    // interrupt status and mask bit positions
    localparam int          ANPS_INT_PAGE      = 0;
    localparam int          ANPS_INT_PDF       = 1;
    localparam int          ANPS_INT_AN        = 2;
    localparam int          ANPS_INT_W         = 3;

    // values after reset and fixed values
    localparam logic [15:0] ANPS_ABILITY_RST   = 16'h0000;
    localparam logic [4:0]  ANPS_SEL_RST       = 5'h00;
    localparam logic [2:0]  ANPS_INT_RST       = 3'h0;
    localparam logic [1:0]  ANPS_RSVD_AB_VAL   = 2'h0;
    localparam logic [10:0] ANPS_RSVD_EX_VAL   = 11'h000;
    localparam logic        ANPS_LOCAL_NP_VAL  = 1'b0;

endpackage : anps_pkg

/* File: anps_sticky.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// sticky flag: set wins over clear
// ----------------------------------------------------------------
module anps_sticky
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag_ff
);

    // hold until cleared, an event in the clearing cycle survives
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_ff <= 1'b0;
        end
        else if (set)
        begin
            flag_ff <= 1'b1;
        end
        else if (clr)
        begin
            flag_ff <= 1'b0;
        end
    end

endmodule : anps_sticky

`default_nettype wire
